// [hw/chan_ctrl_pkg.sv]
// Constants for the timer channel enable and polarity control block.
// Assumes a 32-bit AXI4-Lite register bus and four capture/compare channels.
package chan_ctrl_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] MODE_OFFSET = 8'h18;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h1c;
   localparam logic [ADDR_W-1:0] CEP_OFFSET = 8'h20;
   localparam logic [31:0] CEP_RESET = 32'h0000_0000;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int NUM_CHAN = 4;
   localparam int CHAN_STRIDE = 4;
   localparam int ENABLE_POS = 0;
   localparam int POLARITY_POS = 1;
   localparam int MODE_W = 2;
   localparam int DIV_W = 2;
   localparam int STATUS_OUT_POS = 4;
   localparam logic [31:0] CEP_MASK = 32'h0000_3333;
   // ----------------------------------------------------------------
   // Channel modes and bus answers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_OUTPUT = 2'b00,
      MODE_INPUT_DIRECT = 2'b01,
      MODE_INPUT_CROSS = 2'b10,
      MODE_INPUT_TRIGGER = 2'b11
   } chan_mode_type;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : chan_ctrl_pkg

// [hw/chan_if.sv]
// Signals between the register core and one channel path.
// Assumes all signals are on the aclk domain.
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
   import chan_ctrl_pkg::*;
   logic enable;
   logic polarity;
   logic [MODE_W-1:0] mode;
   logic [DIV_W-1:0] divider;
   logic pin_level;
   logic compare_ref;
   logic out_level;
   logic out_en;
   logic capture;
   logic trig_level;
   modport core (output enable, polarity, mode, divider, pin_level, compare_ref,
      input out_level, out_en, capture, trig_level);
   modport path (input enable, polarity, mode, divider, pin_level, compare_ref,
      output out_level, out_en, capture, trig_level);
endinterface : chan_if
`default_nettype wire

// [hw/chan_path.sv]
// One capture/compare channel: output polarity and gating, input edge
// selection, capture prescaler and capture gating.
// Assumes a synchronised, already filtered input level.
`timescale 1ns/1ps
`default_nettype none
module chan_path (
   input wire logic aclk,
   input wire logic aresetn,
   chan_if.path ch
);
   import chan_ctrl_pkg::*;
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire logic out_mode = (ch.mode == MODE_OUTPUT);
   wire logic in_mode = !out_mode;
   wire logic pol_in = ch.pin_level ^ ch.polarity;
   logic prev_reg;
   logic [2:0] cnt_reg;
   wire logic active_edge = pol_in && !prev_reg;
   wire logic [2:0] cnt_last = 3'((4'h1 << ch.divider) - 4'h1);
   wire logic psc_hit = (cnt_reg == cnt_last);
   wire logic [2:0] cnt_next = !ch.enable ? 3'h0 :
      !active_edge ? cnt_reg : psc_hit ? 3'h0 : 3'(cnt_reg + 3'h1);
   wire logic out_next = ch.enable && out_mode && (ch.compare_ref ^ ch.polarity);
   wire logic cap_next = ch.enable && in_mode && active_edge && psc_hit;
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_reg <= 1'b0;
         cnt_reg <= 3'h0;
         ch.out_level <= 1'b0;
         ch.out_en <= 1'b0;
         ch.capture <= 1'b0;
         ch.trig_level <= 1'b0;
      end else begin
         prev_reg <= pol_in;
         cnt_reg <= cnt_next;
         ch.out_level <= out_next;
         ch.out_en <= ch.enable && out_mode;
         ch.capture <= cap_next;
         ch.trig_level <= pol_in;
      end
   end
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   out_polarity_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ch.enable && ch.mode == MODE_OUTPUT) |=> (ch.out_level == ($past(ch.compare_ref) ^
      $past(ch.polarity)))) else $error("output level does not follow polarity");
   disabled_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ch.enable |=> (!ch.out_en && !ch.out_level)) else $error("disabled channel drives");
   capture_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ch.capture |-> $past(ch.enable) && $past(ch.mode) != MODE_OUTPUT)
      else $error("capture without enabled input channel");
   psc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ch.enable |=> cnt_reg == 3'h0) else $error("prescaler not cleared");
   input_invert_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 ch.trig_level == ($past(ch.pin_level) ^ $past(ch.polarity)))
      else $error("input inversion wrong");
endmodule : chan_path
`default_nettype wire

// [hw/chan_ctrl.sv]
// Channel enable and polarity control with an AXI4-Lite register slave.
// Assumes channel pins are asynchronous; compare references are on aclk.
`timescale 1ns/1ps
`default_nettype none
module chan_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [chan_ctrl_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [chan_ctrl_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [chan_ctrl_pkg::NUM_CHAN-1:0] chan_input,
   input wire logic [chan_ctrl_pkg::NUM_CHAN-1:0] compare_ref,
   input wire logic [chan_ctrl_pkg::NUM_CHAN*chan_ctrl_pkg::DIV_W-1:0] chan_capture_divider,
   output logic [chan_ctrl_pkg::NUM_CHAN-1:0] chan_output,
   output logic [chan_ctrl_pkg::NUM_CHAN-1:0] chan_output_en,
   output logic [chan_ctrl_pkg::NUM_CHAN-1:0] capture_event,
   output logic [chan_ctrl_pkg::NUM_CHAN-1:0] trigger_level
);
   import chan_ctrl_pkg::*;
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [31:0] channel_enable_polarity_reg;
   logic [7:0] mode_reg;
   logic [NUM_CHAN-1:0] sync1_reg;
   logic [NUM_CHAN-1:0] sync2_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic [NUM_CHAN-1:0] enable_vec;
   logic [NUM_CHAN-1:0] out_vec;
   logic [7:0] mode_next;
   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   wire logic do_write = aw_have_reg && w_have_reg && !bvalid;
   wire logic wr_cep = (waddr_reg == CEP_OFFSET);
   wire logic wr_mode = (waddr_reg == MODE_OFFSET);
   wire logic wr_known = wr_cep || wr_mode || (waddr_reg == STATUS_OFFSET);
   wire logic [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
      {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire logic [31:0] cep_merged = ((wdata_reg & strb_mask) |
      (channel_enable_polarity_reg & ~strb_mask)) & CEP_MASK;
   wire logic [7:0] mode_merged = (wdata_reg[7:0] & strb_mask[7:0]) |
      (mode_reg & ~strb_mask[7:0]);
   // ----------------------------------------------------------------
   // Read decode
   // ----------------------------------------------------------------
   wire logic [31:0] status_word = {24'h0, out_vec, trigger_level};
   wire logic rd_known = (araddr == CEP_OFFSET) || (araddr == MODE_OFFSET) ||
      (araddr == STATUS_OFFSET);
   wire logic [31:0] rd_word = (araddr == CEP_OFFSET) ? channel_enable_polarity_reg :
      (araddr == MODE_OFFSET) ? {24'h0, mode_reg} :
      (araddr == STATUS_OFFSET) ? status_word : 32'h0;
   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      chan_if ch ();
      assign ch.enable = channel_enable_polarity_reg[i*CHAN_STRIDE+ENABLE_POS];
      assign ch.polarity = channel_enable_polarity_reg[i*CHAN_STRIDE+POLARITY_POS];
      assign ch.mode = mode_reg[i*MODE_W +: MODE_W];
      assign ch.divider = chan_capture_divider[i*DIV_W +: DIV_W];
      assign ch.pin_level = sync2_reg[i];
      assign ch.compare_ref = compare_ref[i];
      assign enable_vec[i] = ch.enable;
      assign out_vec[i] = ch.out_level;
      assign chan_output[i] = ch.out_level;
      assign chan_output_en[i] = ch.out_en;
      assign capture_event[i] = ch.capture;
      assign trigger_level[i] = ch.trig_level;
      assign mode_next[i*MODE_W +: MODE_W] = (wr_mode && !enable_vec[i]) ?
         mode_merged[i*MODE_W +: MODE_W] : mode_reg[i*MODE_W +: MODE_W];
      chan_path u_path (
         .aclk(aclk),
         .aresetn(aresetn),
         .ch(ch.path)
      );
   end
   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= chan_input;
         sync2_reg <= sync1_reg;
      end
   end
   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_have_reg <= 1'b1;
            waddr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_have_reg <= 1'b1;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_enable_polarity_reg <= CEP_RESET;
         mode_reg <= MODE_RESET;
      end else if (do_write) begin
         if (wr_cep) begin
            channel_enable_polarity_reg <= cep_merged;
         end
         mode_reg <= mode_next;
      end
   end
   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && wr_known) |=> bvalid && bresp == RESP_OKAY)
      else $error("write answer missing");
   write_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && !wr_known) |=> bvalid && bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready) |=> rvalid && !arready) else $error("read answer missing");
   mode_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && wr_mode && enable_vec[0]) |=> mode_reg[1:0] == $past(mode_reg[1:0]))
      else $error("mode changed while enabled");
   reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (channel_enable_polarity_reg & ~CEP_MASK) == 32'h0) else $error("reserved bit set");
   ready_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid |-> !awready && !wready) else $error("write taken while answer pending");
   read_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && !rd_known) |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   cep_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && araddr == CEP_OFFSET) |=>
      rdata == $past(channel_enable_polarity_reg)) else $error("register read wrong");
   mode_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && wr_mode && !enable_vec[0]) |=> mode_reg[1:0] == $past(mode_merged[1:0]))
      else $error("mode write lost while disabled");
   strobe_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && wr_cep && !wstrb_reg[1]) |=>
      channel_enable_polarity_reg[15:8] == $past(channel_enable_polarity_reg[15:8]))
      else $error("masked byte lane written");
endmodule : chan_ctrl
`default_nettype wire

// [verification/chan_far_side.sv]
// Far-side model: channel pin levels, compare references, capture dividers.
// Assumes the bench sets the wanted values; pin levels move off the clock.
`timescale 1ns/1ps
`default_nettype none
module chan_far_side (
   input wire logic aclk,
   input wire logic [3:0] level_set,
   input wire logic [3:0] ref_set,
   input wire logic [7:0] div_set,
   output logic [3:0] chan_input,
   output logic [3:0] compare_ref,
   output logic [7:0] chan_capture_divider
);
   initial begin
      chan_input = 4'h0;
      compare_ref = 4'h0;
      chan_capture_divider = 8'h00;
   end
   always @(level_set) chan_input <= #13 level_set;
   always @(posedge aclk) begin
      compare_ref <= ref_set;
      chan_capture_divider <= div_set;
   end
endmodule : chan_far_side
`default_nettype wire

// [verification/chan_ctrl_bench.sv]
// Self-checking bench for the channel enable and polarity block.
// Assumes the design package and the far-side model in chan_far_side.sv.
`timescale 1ns/1ps
`default_nettype none
module chan_ctrl_bench;
   import chan_ctrl_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0, divs = 0, chan_capture_divider;
   logic [31:0] wdata = 0, rdata, got, pw;
   logic [3:0] wstrb = 4'hf, lvl = 0, refs = 0, en, chan_input, compare_ref;
   logic [3:0] chan_output, chan_output_en, capture_event, trigger_level;
   logic [1:0] bresp, rresp, resp;
   logic awready, wready, bvalid, arready, rvalid;
   int mismatches = 0, comparisons = 0, cycles = 0, cap_cnt[4], cep = 0, mode = 0;
   always #20 aclk = ~aclk;
   chan_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .chan_input, .compare_ref, .chan_capture_divider, .chan_output,
      .chan_output_en, .capture_event, .trigger_level);
   chan_far_side far (.aclk, .level_set(lvl), .ref_set(refs), .div_set(divs), .chan_input,
      .compare_ref, .chan_capture_divider);
   // ----------------------------------------------------------------
   // Capture counting and hang limit
   // ----------------------------------------------------------------
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      for (int i = 0; i < 4; i++) begin
         if (capture_event[i] === 1'b1) cap_cnt[i] <= cap_cnt[i] + 1;
      end
      if (cycles == 5000) begin
         mismatches = mismatches + 1;
         results();
      end
   end
   // ----------------------------------------------------------------
   // Compare, bus and model tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check
   task automatic check_resp(input logic [1:0] g, input logic [1:0] e);
      check({30'h0, g}, {30'h0, e});
   endtask : check_resp
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, ad = 0, wd = 0;
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      do begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         ad |= ta;
         wd |= tw;
      end while (!(ad && wd));
      do begin
         @(negedge aclk);
         ta = bvalid;
         resp = bresp;
         @(posedge aclk);
      end while (!ta);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic t;
      {araddr, arvalid, rready} <= {a, 2'b11};
      do begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
      end while (!t);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         t = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge aclk);
      end while (!t);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic mwr(input logic [7:0] a, input logic [31:0] d);
      logic ok;
      logic [31:0] m;
      ok = (a == CEP_OFFSET) || (a == MODE_OFFSET) || (a == STATUS_OFFSET);
      wr(a, d);
      m = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
      check_resp(resp, ok ? RESP_OKAY : RESP_SLVERR);
      if (a == CEP_OFFSET) cep = ((d & m) | (cep & ~m)) & CEP_MASK;
      for (int i = 0; i < 4; i++) begin
         if (a == MODE_OFFSET && !cep[4*i] && wstrb[0]) mode[2*i+:2] = d[2*i+:2];
      end
   endtask : mwr
   task automatic check_all();
      logic [3:0] o, oe, t;
      repeat (8) @(negedge aclk);
      for (int i = 0; i < 4; i++) begin
         oe[i] = cep[4*i] & (mode[2*i+:2] == 0);
         o[i] = oe[i] & (compare_ref[i] ^ cep[4*i+1]);
         t[i] = chan_input[i] ^ cep[4*i+1];
      end
      check({20'h0, chan_output_en, chan_output, trigger_level}, {20'h0, oe, o, t});
      @(posedge aclk);
      rd(CEP_OFFSET, got);
      check(got, cep);
      check_resp(resp, RESP_OKAY);
      rd(MODE_OFFSET, got);
      check(got, mode);
      rd(STATUS_OFFSET, got);
      check(got, {24'h0, o, t});
   endtask : check_all
   task automatic pulses(input int k);
      repeat (k) begin
         lvl <= 4'hf;
         repeat (6) @(posedge aclk);
         lvl <= 4'h0;
         repeat (6) @(posedge aclk);
      end
   endtask : pulses
   task automatic capture_round(input int k1, input int k2);
      int b[4];
      logic [31:0] ew = 0;
      for (int i = 0; i < 4; i++) ew[4*i] = en[i];
      mwr(CEP_OFFSET, pw);
      mwr(CEP_OFFSET, pw | ew);
      b = cap_cnt;
      pulses(k1);
      mwr(CEP_OFFSET, pw);
      mwr(CEP_OFFSET, pw | ew);
      pulses(k2);
      repeat (6) @(posedge aclk);
      for (int i = 0; i < 4; i++) begin
         check(32'(cap_cnt[i] - b[i]), en[i] ? 32'((k1 >> i) + (k2 >> i)) : 32'h0);
      end
   endtask : capture_round
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h51018728));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check_all();
      mwr(8'h40, 32'hffff_ffff);
      rd(8'h40, got);
      check(got, 32'h0);
      check_resp(resp, RESP_SLVERR);
      mwr(STATUS_OFFSET, 32'h0000_00ff);
      repeat (24) begin
         wstrb <= 4'($urandom);
         mwr(MODE_OFFSET, $urandom);
         mwr(CEP_OFFSET, $urandom & CEP_MASK);
         {lvl, refs} <= 8'($urandom);
         check_all();
      end
      wstrb <= 4'hf;
      mwr(CEP_OFFSET, 32'h0);
      mwr(MODE_OFFSET, 32'h0000_0055);
      {lvl, divs} <= {4'h0, 8'he4};
      pw = 32'h0;
      en = 4'($urandom);
      for (int i = 0; i < 4; i++) pw[4*i+1] = 1'($urandom);
      capture_round(8, 0);
      en = 4'hf;
      capture_round(3, 2);
      results();
   end
endmodule : chan_ctrl_bench
`default_nettype wire
